// ===== rtl/sfr_cfg.svh
// Constants for the supervisor fault response block
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

`define SFR_ACT_NONE 2'h0
`define SFR_ACT_DELAYED 2'h1
`define SFR_RETRY_NONE 3'h0
`define SFR_DEG_ZERO 3'h0
`define SFR_CNT_ONE 3'h1
`define SFR_RESP_RESET 8'h80
`define SFR_TOFF_ONE 16'h0001
`define SFR_TOFF_ZERO 16'h0000
`define SFR_BYTE_ZERO 8'h00

// Sticky status bit positions
`define SFR_VOUT_OV_BIT 7
`define SFR_VOUT_UV_BIT 4
`define SFR_VIN_OV_BIT 7
`define SFR_VIN_UV_BIT 4
`define SFR_TEMP_OT_BIT 7
`define SFR_TEMP_UT_BIT 4
`define SFR_BYTE_OFF_BIT 6
`define SFR_BYTE_VOUT_OV_BIT 5
`define SFR_BYTE_TEMP_BIT 2
`define SFR_BYTE_HIGH_BIT 0
`define SFR_WORD_VOUT_BIT 7
`define SFR_WORD_INPUT_BIT 5

`endif

// ===== rtl/sfr_pkg.sv
// Types shared by the supervisor fault response block
`default_nettype none
package sfr_pkg;
   typedef struct packed {
      logic [1:0] action;
      logic [2:0] retry;
      logic [2:0] deglitch;
   } sfr_resp_t;

   typedef struct packed {
      logic ot;
      logic ut;
      logic vin_ov;
      logic vin_uv;
   } sfr_adc_fault_t;

   typedef enum logic [1:0] {
      SFR_OFF = 2'b00,
      SFR_RUN = 2'b01,
      SFR_SEQ = 2'b10,
      SFR_FAULTED = 2'b11
   } sfr_state_t;
endpackage
`default_nettype wire

// ===== rtl/sfr_deglitch.sv
// Deglitch filter and trip decision for one supervisor fault
`include "sfr_cfg.svh"
`default_nettype none
module sfr_deglitch
   import sfr_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic sample_tick_in,
   input wire logic fault_in,
   input wire sfr_resp_t cfg_in,
   output logic trip_out
);
   logic [2:0] cnt_ff;
   logic trip_ff;
   logic nxt_trip;

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_ff <= `SFR_DEG_ZERO;
      end else if (!fault_in) begin
         cnt_ff <= `SFR_DEG_ZERO;
      end else if (sample_tick_in && cnt_ff < cfg_in.deglitch) begin
         cnt_ff <= cnt_ff + `SFR_CNT_ONE;
      end
   end

   // Upper action bit skips the filter; delayed action waits the count
   always_comb begin
      nxt_trip = 1'b0;
      if (fault_in && cfg_in.action[1]) begin
         nxt_trip = 1'b1;
      end else if (fault_in && cfg_in.action == `SFR_ACT_DELAYED) begin
         nxt_trip = (cnt_ff >= cfg_in.deglitch);
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trip_ff <= 1'b0;
      end else begin
         trip_ff <= nxt_trip;
      end
   end

   assign trip_out = trip_ff;

   a_count_restart: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      !fault_in |=> cnt_ff == `SFR_DEG_ZERO)
      else $error("deglitch count not cleared");
   a_zero_delay: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      fault_in && cfg_in.action == `SFR_ACT_DELAYED
      && cfg_in.deglitch == `SFR_DEG_ZERO |=> trip_ff)
      else $error("zero deglitch did not trip at once");
   a_no_early_trip: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      cfg_in.action == `SFR_ACT_DELAYED && cnt_ff < cfg_in.deglitch
      |=> !trip_ff)
      else $error("fault tripped before deglitch ran out");
endmodule
`default_nettype wire

// ===== rtl/sfr_top.sv
// Per-channel fault response for the high-speed output supervisor
`include "sfr_cfg.svh"
`default_nettype none
module sfr_top
   import sfr_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic sample_tick_in,
   input wire logic ov_detect_in,
   input wire logic uv_detect_in,
   input wire sfr_adc_fault_t adc_fault_in,
   input wire logic current_mode_in,
   input wire logic control_pin_in,
   input wire logic operation_on_in,
   input wire logic shutdown_style_in,
   input wire logic [15:0] toff_ticks_in,
   input wire logic [2:0] retry_limit_in,
   input wire logic other_shutdown_in,
   input wire logic fault_clear_in,
   input wire logic ov_cfg_wr_in,
   input wire logic uv_cfg_wr_in,
   input wire logic [7:0] cfg_wdata_in,
   output logic [7:0] ov_cfg_out,
   output logic [7:0] uv_cfg_out,
   output logic channel_enable_out,
   output logic [2:0] attempts_out,
   output logic [7:0] status_byte_out,
   output logic [7:0] status_word_hi_out,
   output logic [7:0] status_vout_out,
   output logic [7:0] status_vin_out,
   output logic [7:0] status_temp_out,
   output logic alert_request_n_out
);
   sfr_resp_t ov_cfg_ff;
   sfr_resp_t uv_cfg_ff;
   sfr_state_t state_ff;
   logic ctl_meta_ff;
   logic ctl_sync_ff;
   logic [15:0] toff_cnt_ff;
   logic [2:0] attempts_ff;
   logic lock_ff;
   logic enable_ff;
   logic alert_n_ff;
   logic [7:0] st_byte_ff;
   logic [7:0] st_word_ff;
   logic [7:0] st_vout_ff;
   logic [7:0] st_vin_ff;
   logic [7:0] st_temp_ff;
   logic ov_trip;
   logic uv_trip;
   logic vout_trip;
   logic on_cmd;
   logic [2:0] trip_retry;

   // Sticky flag update: a set in the clearing cycle wins
   function automatic logic [7:0] sticky(input logic [7:0] cur,
                                         input logic [7:0] set,
                                         input logic clr);
      sticky = (clr ? `SFR_BYTE_ZERO : cur) | set;
   endfunction

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctl_meta_ff <= 1'b0;
         ctl_sync_ff <= 1'b0;
      end else begin
         ctl_meta_ff <= control_pin_in;
         ctl_sync_ff <= ctl_meta_ff;
      end
   end

   assign on_cmd = ctl_sync_ff && operation_on_in;

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ov_cfg_ff <= `SFR_RESP_RESET;
         uv_cfg_ff <= `SFR_RESP_RESET;
      end else begin
         if (ov_cfg_wr_in) begin
            ov_cfg_ff <= cfg_wdata_in;
         end
         if (uv_cfg_wr_in) begin
            uv_cfg_ff <= cfg_wdata_in;
         end
      end
   end

   sfr_deglitch u_ov (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .sample_tick_in(sample_tick_in),
      .fault_in(ov_detect_in && !current_mode_in),
      .cfg_in(ov_cfg_ff),
      .trip_out(ov_trip)
   );

   sfr_deglitch u_uv (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .sample_tick_in(sample_tick_in),
      .fault_in(uv_detect_in && !current_mode_in),
      .cfg_in(uv_cfg_ff),
      .trip_out(uv_trip)
   );

   assign vout_trip = ov_trip || uv_trip;
   // Overvoltage takes priority when both trip together
   assign trip_retry = ov_trip ? ov_cfg_ff.retry : uv_cfg_ff.retry;

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_ff <= SFR_OFF;
         toff_cnt_ff <= `SFR_TOFF_ZERO;
      end else begin
         unique case (state_ff)
            SFR_OFF: begin
               if (on_cmd && !lock_ff) begin
                  state_ff <= SFR_RUN;
               end
            end
            SFR_RUN: begin
               if (other_shutdown_in) begin
                  state_ff <= SFR_FAULTED;
               end else if (!on_cmd) begin
                  state_ff <= SFR_OFF;
               end else if (vout_trip && shutdown_style_in) begin
                  state_ff <= SFR_SEQ;
                  toff_cnt_ff <= toff_ticks_in;
               end else if (vout_trip) begin
                  state_ff <= SFR_FAULTED;
               end
            end
            SFR_SEQ: begin
               if (other_shutdown_in || toff_cnt_ff == `SFR_TOFF_ZERO) begin
                  state_ff <= SFR_FAULTED;
               end else if (sample_tick_in) begin
                  toff_cnt_ff <= toff_cnt_ff - `SFR_TOFF_ONE;
               end
            end
            SFR_FAULTED: begin
               if (fault_clear_in || !on_cmd) begin
                  state_ff <= SFR_OFF;
               end else if (!lock_ff && attempts_ff < retry_limit_in
                            && sample_tick_in) begin
                  state_ff <= SFR_RUN;
               end
            end
         endcase
      end
   end

   // Lock holds the output off until software clears faults;
   // a trip or other-shutdown lock raised in the clearing cycle wins over the clear; the retry-limit lock does not
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lock_ff <= 1'b0;
      end else if (state_ff == SFR_RUN && vout_trip
                   && trip_retry == `SFR_RETRY_NONE) begin
         lock_ff <= 1'b1;
      end else if (other_shutdown_in && state_ff != SFR_OFF) begin
         lock_ff <= 1'b1;
      end else if (fault_clear_in) begin
         lock_ff <= 1'b0;
      end else if (state_ff == SFR_FAULTED
                   && attempts_ff >= retry_limit_in) begin
         lock_ff <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         attempts_ff <= `SFR_RETRY_NONE;
      end else if (fault_clear_in || !on_cmd) begin
         attempts_ff <= `SFR_RETRY_NONE;
      end else if (state_ff == SFR_FAULTED && !lock_ff
                   && attempts_ff < retry_limit_in && sample_tick_in) begin
         attempts_ff <= attempts_ff + `SFR_CNT_ONE;
      end
   end

   // Channel stays on while sequencing off
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         enable_ff <= 1'b0;
      end else begin
         enable_ff <= (state_ff == SFR_RUN) || (state_ff == SFR_SEQ);
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_vout_ff <= `SFR_BYTE_ZERO;
         st_vin_ff <= `SFR_BYTE_ZERO;
         st_temp_ff <= `SFR_BYTE_ZERO;
      end else begin
         st_vout_ff <= sticky(st_vout_ff,
            (8'(ov_trip) << `SFR_VOUT_OV_BIT)
            | (8'(uv_trip) << `SFR_VOUT_UV_BIT), fault_clear_in);
         st_vin_ff <= sticky(st_vin_ff,
            (8'(adc_fault_in.vin_ov) << `SFR_VIN_OV_BIT)
            | (8'(adc_fault_in.vin_uv) << `SFR_VIN_UV_BIT),
            fault_clear_in);
         st_temp_ff <= sticky(st_temp_ff,
            (8'(adc_fault_in.ot) << `SFR_TEMP_OT_BIT)
            | (8'(adc_fault_in.ut) << `SFR_TEMP_UT_BIT),
            fault_clear_in);
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_byte_ff <= `SFR_BYTE_ZERO;
         st_word_ff <= `SFR_BYTE_ZERO;
      end else begin
         st_byte_ff <= sticky(st_byte_ff,
            (8'(state_ff == SFR_FAULTED) << `SFR_BYTE_OFF_BIT)
            | (8'(ov_trip) << `SFR_BYTE_VOUT_OV_BIT)
            | (8'(adc_fault_in.ot || adc_fault_in.ut)
               << `SFR_BYTE_TEMP_BIT)
            | (8'(vout_trip || adc_fault_in.vin_ov || adc_fault_in.vin_uv)
               << `SFR_BYTE_HIGH_BIT), fault_clear_in);
         st_word_ff <= sticky(st_word_ff,
            (8'(vout_trip) << `SFR_WORD_VOUT_BIT)
            | (8'(adc_fault_in.vin_ov || adc_fault_in.vin_uv)
               << `SFR_WORD_INPUT_BIT), fault_clear_in);
      end
   end

   // Alert follows the sticky VOUT, VIN and temperature status one cycle later
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         alert_n_ff <= 1'b1;
      end else begin
         alert_n_ff <= !(|{st_vout_ff, st_vin_ff, st_temp_ff});
      end
   end

   assign ov_cfg_out = ov_cfg_ff;
   assign uv_cfg_out = uv_cfg_ff;
   assign channel_enable_out = enable_ff;
   assign attempts_out = attempts_ff;
   assign status_byte_out = st_byte_ff;
   assign status_word_hi_out = st_word_ff;
   assign status_vout_out = st_vout_ff;
   assign status_vin_out = st_vin_ff;
   assign status_temp_out = st_temp_ff;
   assign alert_request_n_out = alert_n_ff;

   a_action_none: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      ov_trip |-> $past(ov_cfg_ff.action) != `SFR_ACT_NONE)
      else $error("trip with action none");
   a_current_mode: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      $past(current_mode_in) |-> !ov_trip && !uv_trip)
      else $error("trip in current measurement mode");
   a_fast_shutdown: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      state_ff == SFR_RUN && vout_trip && on_cmd && !other_shutdown_in
      && !shutdown_style_in |=> state_ff == SFR_FAULTED ##1 !enable_ff)
      else $error("immediate shutdown missed");
   a_lock_holds: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      state_ff == SFR_FAULTED && lock_ff && !fault_clear_in
      |=> state_ff != SFR_RUN)
      else $error("restart while locked");
   a_retry_step: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      state_ff == SFR_FAULTED ##1 state_ff == SFR_RUN
      |-> attempts_ff == $past(attempts_ff) + `SFR_CNT_ONE)
      else $error("restart not counted");
   a_retry_clear: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      fault_clear_in || !on_cmd |=> attempts_ff == `SFR_RETRY_NONE)
      else $error("retry count not cleared");
   a_alert_low: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      adc_fault_in.ot |=> st_temp_ff[`SFR_TEMP_OT_BIT] ##1 !alert_n_ff)
      else $error("alert not raised");
   a_vin_status: assert property (
      @(posedge clock_in) disable iff (!nrst_in)
      adc_fault_in.vin_uv |=> st_vin_ff[`SFR_VIN_UV_BIT]
      && st_word_ff[`SFR_WORD_INPUT_BIT])
      else $error("input fault status missing");

   c_ov_trip: cover property (@(posedge clock_in) disable iff (!nrst_in)
      state_ff == SFR_RUN && ov_trip);
   c_seq_off: cover property (@(posedge clock_in) disable iff (!nrst_in)
      state_ff == SFR_SEQ ##1 state_ff == SFR_FAULTED);
   c_restart: cover property (@(posedge clock_in) disable iff (!nrst_in)
      state_ff == SFR_FAULTED ##1 state_ff == SFR_RUN);
   c_alert: cover property (@(posedge clock_in) disable iff (!nrst_in)
      $fell(alert_n_ff));
endmodule
`default_nettype wire

// ===== bench/sfr_host_model.sv
// Host-side model: writes response bytes, commands on/off, clears faults
`default_nettype none
module sfr_host_model (
   input wire logic clock_in,
   output logic ov_cfg_wr_out,
   output logic uv_cfg_wr_out,
   output logic [7:0] cfg_wdata_out,
   output logic control_pin_out,
   output logic operation_on_out,
   output logic fault_clear_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      ov_cfg_wr_out = 1'b0;
      uv_cfg_wr_out = 1'b0;
      cfg_wdata_out = 8'h00;
      control_pin_out = 1'b0;
      operation_on_out = 1'b0;
      fault_clear_out = 1'b0;
   end

   task automatic write_cfg(input logic ov, input logic [7:0] data);
      @(posedge clock_in) #2;
      ov_cfg_wr_out = ov;
      uv_cfg_wr_out = !ov;
      cfg_wdata_out = data;
      @(posedge clock_in) #2;
      ov_cfg_wr_out = 1'b0;
      uv_cfg_wr_out = 1'b0;
      // Stale data would hide a write taken on the wrong edge
      cfg_wdata_out = ~data;
   endtask

   task automatic command(input logic on);
      @(posedge clock_in) #2;
      control_pin_out = on;
      operation_on_out = on;
   endtask

   task automatic clear_faults();
      @(posedge clock_in) #2;
      fault_clear_out = 1'b1;
      @(posedge clock_in) #2;
      fault_clear_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== bench/tb_supervisor_fault_response.sv
// Self-checking bench for the supervisor fault response block
`default_nettype none
module tb_supervisor_fault_response import sfr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock_in = 1'b0;
   logic nrst_in = 1'b0;
   logic tick = 1'b0, ov_det = 1'b0, uv_det = 1'b0, cur_mode = 1'b0;
   logic style = 1'b0, other_sd = 1'b0;
   logic [15:0] toff = 16'h0000;
   logic [2:0] limit = 3'h1;
   sfr_adc_fault_t adc = '0;
   logic ov_wr, uv_wr, fclr, ctl, op_on, en, alert_n;
   logic [7:0] wdata, ov_cfg, uv_cfg, st_byte, st_word, st_vout, st_vin;
   logic [7:0] st_temp, r;
   logic [2:0] att;
   int fails = 0, checks_done = 0, d, lim;

   always #12.5 clock_in = ~clock_in;

   sfr_host_model u_sfr_host_model (.clock_in(clock_in),
      .ov_cfg_wr_out(ov_wr), .uv_cfg_wr_out(uv_wr), .cfg_wdata_out(wdata),
      .control_pin_out(ctl), .operation_on_out(op_on),
      .fault_clear_out(fclr));

   sfr_top u_sfr_top (.clock_in(clock_in), .nrst_in(nrst_in),
      .sample_tick_in(tick), .ov_detect_in(ov_det), .uv_detect_in(uv_det),
      .adc_fault_in(adc), .current_mode_in(cur_mode),
      .control_pin_in(ctl), .operation_on_in(op_on),
      .shutdown_style_in(style), .toff_ticks_in(toff),
      .retry_limit_in(limit), .other_shutdown_in(other_sd),
      .fault_clear_in(fclr), .ov_cfg_wr_in(ov_wr), .uv_cfg_wr_in(uv_wr),
      .cfg_wdata_in(wdata), .ov_cfg_out(ov_cfg), .uv_cfg_out(uv_cfg),
      .channel_enable_out(en), .attempts_out(att),
      .status_byte_out(st_byte), .status_word_hi_out(st_word),
      .status_vout_out(st_vout), .status_vin_out(st_vin),
      .status_temp_out(st_temp), .alert_request_n_out(alert_n));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
         input string msg);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      #2;
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         cyc(1);
         tick = 1'b1;
         cyc(1);
         tick = 1'b0;
      end
   endtask

   task automatic wait_en(input logic exp, input int maxc, input string msg);
      int i;
      i = 0;
      while (en !== exp && i < maxc) begin
         cyc(1);
         i++;
      end
      chk({7'h00, en}, {7'h00, exp}, msg);
   endtask

   task automatic clr();
      u_sfr_host_model.clear_faults();
      cyc(2);
   endtask

   // Group 0 is temperature, group 1 input voltage
   function automatic logic [7:0] adc_exp(input int k, input int grp);
      return (k / 2 != grp) ? 8'h00 : (k[0] ? 8'h10 : 8'h80);
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(25 * 6000);
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      final_report();
   end

   initial begin
      r = 8'($urandom(51));
      cyc(8);
      nrst_in = 1'b1;
      chk(ov_cfg, 8'h80, "ov cfg reset");
      chk(uv_cfg, 8'h80, "uv cfg reset");
      chk(st_byte | st_word | st_vout | st_vin | st_temp, 8'h00, "status");
      chk({5'h00, att} | {7'h00, en}, 8'h00, "enable/attempts reset");
      chk({7'h00, alert_n}, 8'h01, "alert reset");
      for (int k = 0; k < 4; k++) begin
         r = 8'($urandom());
         u_sfr_host_model.write_cfg(k[0], r);
         chk(k[0] ? ov_cfg : uv_cfg, r, "cfg readback");
      end
      $display("test reset/cfg finished");
      u_sfr_host_model.command(1'b1);
      wait_en(1'b1, 10, "power on");
      u_sfr_host_model.write_cfg(1'b1, 8'h00);
      ov_det = 1'b1;
      ticks(8);
      chk({7'h00, en}, 8'h01, "action 00 keeps running");
      ov_det = 1'b0;
      clr();
      $display("test action none finished");
      u_sfr_host_model.write_cfg(1'b1, 8'hC0);
      ov_det = 1'b1;
      wait_en(1'b0, 4, "immediate shutdown");
      chk(st_vout & 8'h80, 8'h80, "vout ov status");
      chk(st_byte & 8'h61, 8'h61, "byte off/ov/high");
      chk(st_word & 8'h80, 8'h80, "word vout");
      chk({7'h00, alert_n}, 8'h00, "vout alert");
      ov_det = 1'b0;
      ticks(4);
      chk({7'h00, en}, 8'h00, "no retry stays off");
      clr();
      wait_en(1'b1, 6, "on after clear");
      chk({7'h00, alert_n}, 8'h01, "alert released");
      $display("test immediate finished");
      u_sfr_host_model.write_cfg(1'b0, 8'h40);
      uv_det = 1'b1;
      wait_en(1'b0, 4, "deglitch zero trips at once");
      uv_det = 1'b0;
      clr();
      wait_en(1'b1, 6, "on after clear");
      // At least two, so the first burst leaves a partial count to lose
      d = 2 + $urandom_range(5);
      u_sfr_host_model.write_cfg(1'b0, {2'h1, 3'h0, d[2:0]});
      uv_det = 1'b1;
      ticks(d - 1);
      uv_det = 1'b0;
      cyc(1);
      uv_det = 1'b1;
      ticks(d - 1);
      cyc(4);
      chk({7'h00, en}, 8'h01, "deglitch holds off");
      ticks(1);
      wait_en(1'b0, 6, "deglitch expires");
      chk(st_vout & 8'h10, 8'h10, "vout uv status");
      uv_det = 1'b0;
      clr();
      wait_en(1'b1, 6, "on after clear");
      $display("test deglitch %0d finished", d);
      cur_mode = 1'b1;
      u_sfr_host_model.write_cfg(1'b1, 8'hC0);
      u_sfr_host_model.write_cfg(1'b0, 8'hC0);
      ov_det = 1'b1;
      uv_det = 1'b1;
      ticks(3);
      chk({7'h00, en}, 8'h01, "current mode ignores");
      chk(st_vout, 8'h00, "current mode no status");
      ov_det = 1'b0;
      uv_det = 1'b0;
      cur_mode = 1'b0;
      cyc(1);
      style = 1'b1;
      toff = 16'h0003;
      ov_det = 1'b1;
      cyc(6);
      chk({7'h00, en}, 8'h01, "sequence off waits");
      ticks(5);
      wait_en(1'b0, 6, "sequence off done");
      ov_det = 1'b0;
      style = 1'b0;
      clr();
      wait_en(1'b1, 6, "on after clear");
      $display("test mode/style finished");
      lim = 1 + $urandom_range(2);
      limit = lim[2:0];
      u_sfr_host_model.write_cfg(1'b1, 8'hC8);
      ov_det = 1'b1;
      ticks(4 * lim + 6);
      chk({5'h00, att}, lim[7:0], "attempts at limit");
      ov_det = 1'b0;
      ticks(3);
      chk({7'h00, en}, 8'h00, "locked at limit");
      u_sfr_host_model.command(1'b0);
      cyc(4);
      chk({5'h00, att}, 8'h00, "attempts cleared");
      clr();
      u_sfr_host_model.command(1'b1);
      wait_en(1'b1, 10, "on again");
      limit = 3'h7;
      ov_det = 1'b1;
      wait_en(1'b0, 4, "trip before other fault");
      ov_det = 1'b0;
      other_sd = 1'b1;
      cyc(1);
      other_sd = 1'b0;
      ticks(6);
      chk({7'h00, en}, 8'h00, "other fault stops retry");
      clr();
      wait_en(1'b1, 6, "on after clear");
      $display("test retry %0d finished", lim);
      for (int k = 0; k < 4; k++) begin
         adc = sfr_adc_fault_t'(4'h8 >> k);
         cyc(1);
         adc = '0;
         cyc(3);
         chk(st_temp, adc_exp(k, 0), "temp status");
         chk(st_vin, adc_exp(k, 1), "vin status");
         chk(st_byte & 8'h04, adc_exp(k, 0) != 0 ? 8'h04 : 8'h00, "b");
         chk(st_word & 8'h20, adc_exp(k, 1) != 0 ? 8'h20 : 8'h00, "w");
         chk({7'h00, alert_n}, 8'h00, "adc alert");
         clr();
      end
      $display("test adc faults finished");
      final_report();
   end
endmodule
`default_nettype wire
